// ### bench/testbench.sv
// Self-checking bench of the power mode and write arbitration block.
`timescale 1ns/1ps
module testbench;
    import tpa_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic         clock_i = 1'b0;
    logic         resetn_i = 1'b0;
    logic         field = 1'b0, ext = 1'b0, low = 1'b0, prot = 1'b0;
    logic [1:0]   idx;
    logic [7:0]   nvd, rdata, wdata = 8'h00, rd;
    logic [3:0]   addr = 4'h0;
    logic         wr_s = 1'b0, rd_s = 1'b0, h_req = 1'b0, h_done = 1'b0;
    tpa_rf_req_t  rf_req = '0;
    logic         grant, nak, ok, hgrant, abort, rf_en, pwr, auth, irq;
    logic [4:0]   g;
    tpa_harvest_t harv;
    int           fail_count = 0, tests_run = 0, i, pm, k;
    int           c1, c0, rr, en, v;

    always #2.5 clock_i = ~clock_i;

    tpa_nv_model NV (.nv_cfg_index_i(idx), .nv_cfg_data_o(nvd));
    tpa_arbiter DUT (
        .clock_i(clock_i), .resetn_i(resetn_i),
        .field_power_on_detect_i(field), .external_supply_pin_i(ext),
        .supply_low_i(low), .nv_cfg_data_i(nvd), .nv_cfg_index_o(idx),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s),
        .reg_read_i(rd_s), .reg_rdata_o(rdata), .rf_req_i(rf_req),
        .host_write_req_i(h_req), .host_write_done_i(h_done),
        .rf_protected_i(prot), .rf_write_grant_o(grant), .rf_nak_o(nak),
        .rf_access_ok_o(ok), .host_write_grant_o(hgrant),
        .host_write_abort_o(abort), .rf_enable_o(rf_en),
        .logic_powered_o(pwr), .authenticated_o(auth), .harvest_o(harv),
        .irq_o(irq));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a; wdata <= d; wr_s <= 1'b1;
        @(posedge clock_i);
        wr_s <= 1'b0;
    endtask

    // Read data is valid only in the cycle after the strobe.
    task automatic rdr(input logic [3:0] a);
        @(posedge clock_i);
        addr <= a; rd_s <= 1'b1;
        @(posedge clock_i);
        rd_s <= 1'b0;
        #1 rd = rdata;
    endtask

    // Grants and refusals are combinational, so they are taken mid-cycle.
    task automatic req(input logic [7:0] r, input logic h, input logic d);
        @(posedge clock_i);
        rf_req <= tpa_rf_req_t'(r); h_req <= h; h_done <= d;
        #1 g = {grant, nak, hgrant, abort, ok};
        @(posedge clock_i);
        rf_req <= '0; h_req <= 1'b0; h_done <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(32'h06afd778));
        repeat (16) @(posedge clock_i);
        resetn_i <= 1'b1;
        field <= 1'b1;
        for (i = 0; i < 60 && pwr !== 1'b1; i++) @(posedge clock_i);
        if (pwr !== 1'b1) begin
            fail_count++;
            $display("MISMATCH %0t block never powered up", $time);
            finish_test();
        end
        rdr(ADDR_CFG0); chk(rd, 8'h04);
        rdr(ADDR_CFG1); chk(rd, 8'h4B);
        rdr(ADDR_CFG2); chk(rd[1:0], 2'h0);
        rdr(ADDR_IRQ); chk(rd[IRQ_WAKE_BIT], 1'b1);
        settle(1); chk(irq, 1'b0);
        // Harvest decode across all power modes with random settings.
        ext <= 1'b1;
        for (pm = 0; pm < 4; pm++) begin
            for (k = 0; k < 6; k++) begin
                c1 = $urandom & 8'h7F;
                c0 = $urandom & 8'h0C;
                wr(ADDR_CFG0, c0[7:0]);
                wr(ADDR_CFG1, c1[7:0]);
                wr(ADDR_CFG2, pm[7:0]);
                settle(2);
                rr = c1[6:5];
                if (pm == 1 && c0[3:2] == 0) rr = 0;
                en = (pm < 2 && rr != 0);
                v = (c1[4:0] <= 26) ? 19 + c1[4:0] : 18;
                chk(harv.enable, en[0]);
                if (pm < 2) chk(harv.rreg, rr[1:0]);
                chk(harv.vreg, c1[4:0]);
                chk(harv.volt_100mv, v[5:0]);
            end
        end
        // External supply keeps the block alive without a field.
        wr(ADDR_CFG2, 8'h02);
        field <= 1'b0;
        settle(8); chk(pwr, 1'b1);
        field <= 1'b1;
        wr(ADDR_CFG2, 8'h00);
        wr(ADDR_CFG0, 8'h00);
        rdr(ADDR_IRQ);
        req(8'h00, 1'b1, 1'b0); chk(g[2], 1'b1);
        req(8'h80, 1'b0, 1'b0); chk(g[4:3], 2'b01);
        req(8'h00, 1'b0, 1'b1);
        req(8'h80, 1'b0, 1'b0); chk(g[4], 1'b1);
        req(8'h00, 1'b1, 1'b0); chk(g[2], 1'b0);
        settle(1); chk(irq, 1'b1);
        req(8'h20, 1'b0, 1'b0);
        settle(4); chk(irq, 1'b1);
        rdr(ADDR_IRQ); chk(rd[IRQ_ERR_BIT], 1'b1);
        wr(ADDR_CFG0, 8'h01);
        req(8'h00, 1'b1, 1'b0); chk(g[2], 1'b1);
        req(8'h40, 1'b0, 1'b0); chk(g[1], 1'b1);
        settle(1); chk(irq, 1'b1);
        rdr(ADDR_IRQ); chk(rd[IRQ_ERR_BIT], 1'b1);
        req(8'h00, 1'b1, 1'b0); chk(g[2], 1'b1);
        req(8'h00, 1'b0, 1'b1);
        // Silent mode with a weak supply shuts the RF side.
        wr(ADDR_CFG0, 8'h02);
        low <= 1'b1;
        settle(6); chk(rf_en, 1'b0);
        req(8'h80, 1'b0, 1'b0); chk(g[4], 1'b0);
        low <= 1'b0;
        settle(6); chk(rf_en, 1'b1);
        // Password attempts: the seventh failure locks.
        prot <= 1'b1;
        req(8'h80, 1'b0, 1'b0); chk({g[4], g[0]}, 2'b00);
        for (i = 1; i <= 7; i++) begin
            req(8'h10, 1'b0, 1'b0);
            settle(1);
            rdr(ADDR_STATUS); chk(rd[6], (i == 7));
        end
        req(8'h18, 1'b0, 1'b0);
        settle(1); chk(auth, 1'b0);
        wr(ADDR_AUTH, 8'h00);
        req(8'h18, 1'b0, 1'b0);
        settle(1); chk(auth, 1'b1);
        req(8'h80, 1'b0, 1'b0); chk({g[4], g[0]}, 2'b11);
        req(8'h20, 1'b0, 1'b0);
        prot <= 1'b0;
        // Field arrival aborts a host write under RF priority.
        wr(ADDR_CFG0, 8'h01);
        field <= 1'b0;
        settle(4); rdr(ADDR_IRQ);
        req(8'h00, 1'b1, 1'b0); chk(g[2], 1'b1);
        field <= 1'b1;
        settle(4); rdr(ADDR_STATUS); chk(rd[5:4], 2'b00);
        rdr(ADDR_IRQ); chk(rd[IRQ_ERR_BIT], 1'b1);
        // A sleep request raises the wake flag.
        rdr(ADDR_IRQ);
        req(8'h02, 1'b0, 1'b0);
        settle(2); chk(irq, 1'b1);
        rdr(ADDR_IRQ); chk(rd[IRQ_WAKE_BIT], 1'b1);
        finish_test();
    end
endmodule

// ### bench/tpa_nv_model.sv
// Nonvolatile configuration store seen by the block during initialization.
`timescale 1ns/1ps
// ==========================================================
// Store model
// ==========================================================
module tpa_nv_model #(
    parameter logic [7:0] CFG0_BYTE = 8'h04,
    parameter logic [7:0] CFG1_BYTE = 8'h4B,
    parameter logic [7:0] MODE_BYTE = 8'h00
) (
    input  wire logic [1:0] nv_cfg_index_i,
    output logic [7:0]      nv_cfg_data_o
);
    // Index 3 is not a stored byte, so it returns a fixed pattern.
    always_comb begin
        case (nv_cfg_index_i)
            2'h0:    nv_cfg_data_o = CFG0_BYTE;
            2'h1:    nv_cfg_data_o = CFG1_BYTE;
            2'h2:    nv_cfg_data_o = MODE_BYTE;
            default: nv_cfg_data_o = 8'hA5;
        endcase
    end
endmodule

// ### design/tpa_arbiter.sv
// Power mode control, EEPROM write arbitration and RF gating of the tag.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// ==========================================================
// Notes on behaviour
// (R1) Host idles SPI lines high for standby.
// (R2) Field mode: regulator powers system only if tunnel/extended.
// (R3) Field mode otherwise forces resistance field zero.
// (R4) External modes never shut down while supply present.
// (R5) External modes entered only after initialization.
// (R6) Host boots mode 0/1, switches via register two.
// (R7) Host returns to mode 0/1 before removing supply.
// (R8) Initialization copies every config byte to registers.
// (R9) Mode 0 starts on field or supply; mode 1 field.
// (R10) Arbitration mode chosen by config byte zero bit.
// (R11) Idle EEPROM: either side may start a write.
// (R12) Mode 0: RF write during host write gets NAK.
// (R13) Mode 0: host write during RF write raises error.
// (R14) Mode 1: field turn-on aborts host write, error.
// (R15) Mode 1: RF read/write aborts host write, error.
// (R16) Host repeats an aborted write.
// (R17) Harvesting only in power modes 0 and 1.
// (R18) Resistance field decodes to off,100,50,25 ohms.
// (R19) Voltage code linear 1.9V..4.5V, high codes 1.8V.
// (R20) Silent mode with low supply disables RF side.
// (R21) Seven failed password attempts lock authentication.
// (R22) Password checks apply to RF accesses only.
// (R23) Wake-up interrupt on selectable events.
// (R24) Interrupt flags hold until host clears them.
// ==========================================================
module tpa_arbiter
    import tpa_pkg::*;
#(
    parameter int NV_COUNT = NV_BYTES
) (
    input  wire logic         clock_i,
    input  wire logic         resetn_i,
    input  wire logic         field_power_on_detect_i,
    input  wire logic         external_supply_pin_i,
    input  wire logic         supply_low_i,
    input  wire logic [7:0]   nv_cfg_data_i,
    output logic [1:0]        nv_cfg_index_o,
    input  wire logic [3:0]   reg_addr_i,
    input  wire logic [7:0]   reg_wdata_i,
    input  wire logic         reg_write_i,
    input  wire logic         reg_read_i,
    output logic [7:0]        reg_rdata_o,
    input  wire tpa_rf_req_t  rf_req_i,
    input  wire logic         host_write_req_i,
    input  wire logic         host_write_done_i,
    input  wire logic         rf_protected_i,
    output logic              rf_write_grant_o,
    output logic              rf_nak_o,
    output logic              rf_access_ok_o,
    output logic              host_write_grant_o,
    output logic              host_write_abort_o,
    output logic              rf_enable_o,
    output logic              logic_powered_o,
    output logic              authenticated_o,
    output tpa_harvest_t      harvest_o,
    output logic              irq_o
);

    if (NV_COUNT != NV_BYTES) begin
        $error("tpa_arbiter: NV_COUNT must equal three");
    end

    // ==========================================================
    // Input synchronisers for pin-level signals
    // ==========================================================
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic       field_d;
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            field_d <= 1'b0;
        end else begin
            sync1 <= {supply_low_i, external_supply_pin_i,
                      field_power_on_detect_i};
            sync2 <= sync1;
            field_d <= sync2[0];
        end
    end
    wire field_on   = sync2[0];
    wire ext_on     = sync2[1];
    wire vio_low    = sync2[2];
    wire field_rise = field_on & ~field_d;

    // ==========================================================
    // Power mode and initialization
    // ==========================================================
    tpa_state_t state;
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    tpa_pm_t    pm;
    logic [1:0] load_idx;

    tpa_pm_t nv_pm;
    assign nv_pm = tpa_pm_t'(nv_cfg_data_i[1:0]);
    wire ext_mode = (pm == TPA_PM_EXT2) || (pm == TPA_PM_EXT3);
    // A boot trigger is judged from the mode register pm, which reset sets to mode 0; see (R9).
    wire start_init = field_on || ((pm == TPA_PM_AUTO) && ext_on);
    wire host_cfg_wr = reg_write_i && (state == TPA_ST_RUN);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state <= TPA_ST_OFF;
            load_idx <= 2'h0;
        end else begin
            case (state)
                TPA_ST_OFF: begin
                    if (start_init) begin // see (R9)
                        state <= TPA_ST_LOAD;
                    end
                    load_idx <= 2'h0;
                end
                TPA_ST_LOAD: begin
                    if (load_idx == 2'(NV_COUNT - 1)) begin // see (R8)
                        state <= TPA_ST_RUN;
                    end
                    load_idx <= load_idx + 2'h1;
                end
                TPA_ST_RUN: begin
                    // External modes stay up while supply is there.
                    if (ext_mode ? !ext_on : !start_init) begin // see (R4)
                        state <= TPA_ST_OFF;
                    end
                end
                default: state <= TPA_ST_OFF;
            endcase
        end
    end
    assign nv_cfg_index_o = load_idx;
    assign logic_powered_o = (state == TPA_ST_RUN);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            cfg0 <= CFG0_RESET;
            cfg1 <= CFG1_RESET;
            pm <= TPA_PM_AUTO;
        end else if (state == TPA_ST_LOAD) begin
            case (load_idx) // see (R8)
                2'h0: cfg0 <= nv_cfg_data_i;
                2'h1: cfg1 <= nv_cfg_data_i;
                // Nonvolatile mode may only be 0 or 1; top bit dropped.
                default: pm <= tpa_pm_t'({1'b0, nv_pm[0]});
            endcase
        end else if (host_cfg_wr) begin
            // Config register writes only land after init completes; see (R5)
            case (reg_addr_i)
                ADDR_CFG0: cfg0 <= reg_wdata_i;
                ADDR_CFG1: cfg1 <= reg_wdata_i;
                ADDR_CFG2: pm <= tpa_pm_t'(reg_wdata_i[1:0]);
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Harvest regulator decode
    // ==========================================================
    function automatic logic [5:0] vreg_volts(input logic [4:0] code);
        if (code > VREG_TOP_CODE) begin
            vreg_volts = VREG_LOW_MV10; // see (R19)
        end else begin
            vreg_volts = VREG_BASE + {1'b0, code}; // see (R19)
        end
    endfunction

    wire tunnel_ext = cfg0[CFG0_TUNNEL_BIT] | cfg0[CFG0_EXT_BIT];
    logic [1:0] rreg_eff;
    always_comb begin
        rreg_eff = cfg1[CFG1_RREG_LSB +: 2];
        if ((pm == TPA_PM_FIELD) && !tunnel_ext) begin
            rreg_eff = 2'b00; // see (R3)
        end
        if (ext_mode || !logic_powered_o) begin
            rreg_eff = 2'b00; // see (R17)
        end
    end

    // 00 tristates the pin; 01/10/11 pick 100, 50 and 25 ohms.
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            harvest_o <= '0;
        end else begin
            harvest_o.enable <= (rreg_eff != 2'b00); // see (R2) (R18)
            harvest_o.rreg <= rreg_eff; // see (R18)
            harvest_o.vreg <= cfg1[4:0];
            harvest_o.volt_100mv <= vreg_volts(cfg1[4:0]);
        end
    end

    // ==========================================================
    // Silent mode gate
    // ==========================================================
    wire rf_on = logic_powered_o && field_on &&
                 !(cfg0[CFG0_SILENT_BIT] && vio_low);
    assign rf_enable_o = rf_on; // see (R20)
    tpa_rf_req_t rf;
    assign rf = rf_on ? rf_req_i : '0; // see (R20)

    // ==========================================================
    // EEPROM write arbitration
    // ==========================================================
    tpa_wr_t wr;
    wire rf_prio = cfg0[CFG0_ARB_BIT]; // see (R10)
    wire host_abort = rf_prio && (wr == TPA_WR_HOST) &&
                      (field_rise || rf.read_req || rf.write_req);
    wire rf_wr_ok = rf.write_req &&
                    ((wr == TPA_WR_IDLE) || host_abort) &&
                    !(rf_protected_i && !authenticated_o);
    wire host_wr_ok = host_write_req_i && (wr == TPA_WR_IDLE) &&
                      !rf.write_req && logic_powered_o;
    wire host_clash = host_write_req_i && (wr == TPA_WR_RF);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            wr <= TPA_WR_IDLE;
        end else begin
            case (wr)
                TPA_WR_IDLE: begin
                    if (rf_wr_ok) begin // see (R11)
                        wr <= TPA_WR_RF;
                    end else if (host_wr_ok) begin // see (R11)
                        wr <= TPA_WR_HOST;
                    end
                end
                TPA_WR_RF: begin
                    if (rf_req_i.write_done || !rf_on) begin
                        wr <= TPA_WR_IDLE;
                    end
                end
                TPA_WR_HOST: begin
                    if (host_abort) begin // see (R14) (R15)
                        wr <= rf_wr_ok ? TPA_WR_RF : TPA_WR_IDLE;
                    end else if (host_write_done_i) begin
                        wr <= TPA_WR_IDLE;
                    end
                end
                default: wr <= TPA_WR_IDLE;
            endcase
        end
    end
    assign rf_write_grant_o = rf_wr_ok;
    assign host_write_grant_o = host_wr_ok;
    assign host_write_abort_o = host_abort;
    // Mode 0 refuses the RF write while the host owns the array.
    assign rf_nak_o = rf.write_req && !rf_wr_ok; // see (R12) (R22)
    // Host accesses never pass this check; only RF ones do.
    assign rf_access_ok_o = (rf.read_req || rf.write_req) &&
                            !(rf_protected_i && !authenticated_o); // see (R22)

    // ==========================================================
    // Password authentication
    // ==========================================================
    logic [2:0] fail_cnt;
    logic       auth;
    wire        locked = (fail_cnt == AUTH_MAX_FAIL);
    always_ff @(posedge clock_i) begin
        if (!resetn_i || state != TPA_ST_RUN) begin
            auth <= 1'b0;
        end else if (rf.pwd_write && !auth && !locked) begin
            auth <= rf.pwd_match; // see (R21)
        end
    end
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            fail_cnt <= 3'h0;
        end else if (host_cfg_wr && reg_addr_i == ADDR_AUTH) begin
            fail_cnt <= reg_wdata_i[2:0];
        end else if (rf.pwd_write && !auth && !locked &&
                     !rf.pwd_match) begin
            fail_cnt <= fail_cnt + 3'h1; // see (R21)
        end
    end
    assign authenticated_o = auth;

    // ==========================================================
    // Interrupt flags and wake-up selection
    // ==========================================================
    logic [3:0] wake_en;
    logic [1:0] irq_flags;
    logic       init_done_d;
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            wake_en <= WAKEEN_RESET;
            init_done_d <= 1'b0;
        end else begin
            init_done_d <= logic_powered_o;
            if (host_cfg_wr && reg_addr_i == ADDR_WAKEEN) begin
                wake_en <= reg_wdata_i[3:0];
            end
        end
    end
    wire [3:0] wake_src = {rf.mem_updated, rf.sleep_req, rf.selected,
                           logic_powered_o & ~init_done_d};
    wire wake_ev = |(wake_src & wake_en); // see (R23)
    wire err_ev = (host_clash && !rf_prio) || host_abort; // see (R13)
    wire irq_rd = reg_read_i && reg_addr_i == ADDR_IRQ;
    wire [1:0] irq_wclr = (reg_write_i && reg_addr_i == ADDR_IRQ) ?
                          reg_wdata_i[1:0] : 2'b00;

    // A read or write-one clears a flag, but a new event wins.
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            irq_flags <= 2'b00;
        end else begin
            irq_flags[IRQ_ERR_BIT] <= err_ev ||
                (irq_flags[IRQ_ERR_BIT] && !irq_rd &&
                 !irq_wclr[IRQ_ERR_BIT]); // see (R24)
            irq_flags[IRQ_WAKE_BIT] <= wake_ev ||
                (irq_flags[IRQ_WAKE_BIT] && !irq_rd &&
                 !irq_wclr[IRQ_WAKE_BIT]); // see (R24)
        end
    end
    assign irq_o = |irq_flags;

    // ==========================================================
    // Register read port
    // ==========================================================
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_read_i) begin
            case (reg_addr_i)
                ADDR_CFG0:   reg_rdata_o <= cfg0;
                ADDR_CFG1:   reg_rdata_o <= cfg1;
                ADDR_CFG2:   reg_rdata_o <= {6'h00, pm};
                ADDR_STATUS: reg_rdata_o <= {1'b0, locked, wr, state,
                                             rf_on, auth};
                ADDR_IRQ:    reg_rdata_o <= {6'h00, irq_flags};
                ADDR_WAKEEN: reg_rdata_o <= {4'h0, wake_en};
                ADDR_AUTH:   reg_rdata_o <= {5'h00, fail_cnt};
                ADDR_HARV:   reg_rdata_o <= {harvest_o.enable,
                                             harvest_o.rreg,
                                             harvest_o.vreg};
                default:     reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    a_field_mode_off: assert property (@(posedge clock_i) // see (R3)
        disable iff (!resetn_i)
        (pm == TPA_PM_FIELD && !tunnel_ext) |=> !harvest_o.enable)
        else $error("harvest on in field mode without tunnel");
    a_ext_no_harvest: assert property (@(posedge clock_i) // see (R17)
        disable iff (!resetn_i)
        ext_mode |=> harvest_o.rreg == 2'b00)
        else $error("harvest active in external mode");
    a_ext_stays_up: assert property (@(posedge clock_i) // see (R4)
        disable iff (!resetn_i)
        (logic_powered_o && ext_mode && ext_on) |=> logic_powered_o)
        else $error("shutdown with external supply present");
    a_rf_nak_busy: assert property (@(posedge clock_i) // see (R12)
        disable iff (!resetn_i)
        (!rf_prio && wr == TPA_WR_HOST && rf.write_req) |-> rf_nak_o)
        else $error("RF write not refused during host write");
    a_host_err_irq: assert property (@(posedge clock_i) // see (R13)
        disable iff (!resetn_i)
        (!rf_prio && host_clash) |=> irq_flags[IRQ_ERR_BIT])
        else $error("host clash did not flag error");
    a_abort_on_rf: assert property (@(posedge clock_i) // see (R15)
        disable iff (!resetn_i)
        (rf_prio && wr == TPA_WR_HOST && rf.read_req)
        |-> host_write_abort_o ##1 (wr != TPA_WR_HOST))
        else $error("host write not aborted by RF access");
    a_abort_on_field: assert property (@(posedge clock_i) // see (R14)
        disable iff (!resetn_i)
        (rf_prio && wr == TPA_WR_HOST && field_rise) |-> host_write_abort_o)
        else $error("host write not aborted by field arrival");
    a_silent_gate: assert property (@(posedge clock_i) // see (R20)
        disable iff (!resetn_i)
        (cfg0[CFG0_SILENT_BIT] && vio_low) |-> !rf_enable_o)
        else $error("RF enabled in silent mode");
    a_auth_lock: assert property (@(posedge clock_i) // see (R21)
        disable iff (!resetn_i)
        (locked && !auth) |=> !auth)
        else $error("authenticated while locked");
    a_vreg_decode: assert property (@(posedge clock_i) // see (R19)
        disable iff (!resetn_i)
        $changed(cfg1) ##1 (cfg1[4:0] > VREG_TOP_CODE)
        |-> harvest_o.volt_100mv == VREG_LOW_MV10)
        else $error("high voltage code not mapped low");
    c_init_done: cover property (@(posedge clock_i)
        state == TPA_ST_LOAD ##[1:4] state == TPA_ST_RUN);
    c_host_abort: cover property (@(posedge clock_i) host_write_abort_o);
    c_rf_nak: cover property (@(posedge clock_i) rf_nak_o);

endmodule

// ### design/tpa_pkg.sv
// Package with constants and carrier types of the tag power and access block.
package tpa_pkg;

    // ==========================================================
    // Register map of the plain register port
    // ==========================================================
    localparam logic [3:0] ADDR_CFG0   = 4'h0;
    localparam logic [3:0] ADDR_CFG1   = 4'h1;
    localparam logic [3:0] ADDR_CFG2   = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_IRQ    = 4'h4;
    localparam logic [3:0] ADDR_WAKEEN = 4'h5;
    localparam logic [3:0] ADDR_AUTH   = 4'h6;
    localparam logic [3:0] ADDR_HARV   = 4'h7;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CFG0_ARB_BIT    = 0;
    localparam int CFG0_SILENT_BIT = 1;
    localparam int CFG0_TUNNEL_BIT = 2;
    localparam int CFG0_EXT_BIT    = 3;
    localparam int CFG1_RREG_LSB   = 5;
    localparam int IRQ_ERR_BIT     = 0;
    localparam int IRQ_WAKE_BIT    = 1;

    // ==========================================================
    // Reset values, limits and counts
    // ==========================================================
    localparam logic [7:0] CFG0_RESET    = 8'h00;
    localparam logic [7:0] CFG1_RESET    = 8'h00;
    localparam logic [3:0] WAKEEN_RESET  = 4'hF;
    localparam logic [2:0] AUTH_MAX_FAIL = 3'h7;
    localparam logic [4:0] VREG_TOP_CODE = 5'h1A;
    localparam logic [5:0] VREG_LOW_MV10 = 6'h12;
    localparam logic [5:0] VREG_BASE     = 6'h13;
    localparam int NV_BYTES = 3;

    typedef enum logic [1:0] {
        TPA_PM_AUTO  = 2'b00,
        TPA_PM_FIELD = 2'b01,
        TPA_PM_EXT2  = 2'b10,
        TPA_PM_EXT3  = 2'b11
    } tpa_pm_t;

    typedef enum logic [1:0] {
        TPA_ST_OFF  = 2'b00,
        TPA_ST_LOAD = 2'b01,
        TPA_ST_RUN  = 2'b10
    } tpa_state_t;

    typedef enum logic [1:0] {
        TPA_WR_IDLE = 2'b00,
        TPA_WR_RF   = 2'b01,
        TPA_WR_HOST = 2'b10
    } tpa_wr_t;

    // Harvest regulator settings presented to the analog side.
    typedef struct packed {
        logic       enable;
        logic [1:0] rreg;
        logic [4:0] vreg;
        logic [5:0] volt_100mv;
    } tpa_harvest_t;

    // Requests arriving from the RF side command decoder.
    typedef struct packed {
        logic write_req;
        logic read_req;
        logic write_done;
        logic pwd_write;
        logic pwd_match;
        logic selected;
        logic sleep_req;
        logic mem_updated;
    } tpa_rf_req_t;

endpackage
